// ===== src/out2_gain_regs.svh
// register indices, field positions, reset values for output two gain bank
`ifndef OUT2_GAIN_REGS_SVH
`define OUT2_GAIN_REGS_SVH

// register indices; byte address is four times the index
`define CFG_IDX 8'h6D
`define VOL_IDX 8'h6E
`define FINE_IDX 8'h6F
`define BW_IDX 8'h40
`define STAT_IDX 8'h41

// reset values
`define CFG_RST 8'h20
`define VOL_RST 8'hC9
`define FINE_RST 8'h80
`define BW_RST 8'h00

// configuration field positions
`define DRV_HI 7
`define DRV_LO 6
`define LVL_HI 5
`define LVL_LO 3
`define BYP_BIT 2
`define FS_BIT 1
`define CM_BIT 0

// fine gain field positions
`define FG_HI 7
`define FG_LO 4

// gain reference codes
`define VOL_UNITY 9'h0C9
`define FG_UNITY 5'h08
`define LVL_RSVD 3'h7
`define LVL_M12 3'h6

`endif

// ===== src/out2_gain_pkg.sv
// types for the output two gain register bank
package out2_gain_pkg;

    // negative leg driver choices
    typedef enum logic [1:0] {
        drv_line_out = 2'h0,
        drv_headphone = 2'h1,
        drv_four_ohm = 2'h2,
        drv_receiver = 2'h3
    } drive_t;

    // analogue configuration seen by the output stage
    typedef struct packed {
        drive_t neg_leg_drive_sel;
        logic [2:0] neg_leg_level_sel;
        logic pos_bypass_impedance_sel;
        logic full_scale_sel;
        logic common_mode_tolerance_sel;
        logic channel_bandwidth_sel;
    } analog_cfg_t;

    // digital gain seen by the channel a signal path
    typedef struct packed {
        logic mute;
        logic signed [8:0] volume_half_db;
        logic signed [4:0] fine_tenth_db;
    } gain_t;

endpackage

// ===== src/output_two_dac_gain_regs.sv
// apb register bank for output two and dac channel 2a gain
//
// What this block does
// [RQ1] config register at 0x6D, reset 0x20
// [RQ2] bits 7-6 select negative leg driver
// [RQ3] bits 5-3 level, code 4 0 dB
// [RQ4] host uses level codes 0-6 only, 7 reserved
// [RQ5] host uses level 6 only with 4.4k
// [RQ6] bit 2 bypass impedance 4.4k or 20k
// [RQ7] bit 1 selects full scale range
// [RQ8] host enables high scale only audio band
// [RQ9] bit 0 selects common mode tolerance
// [RQ10] volume register at 0x6E, reset 0xC9
// [RQ11] volume code zero mutes channel a
// [RQ12] codes 1-255 half dB, 201 unity
// [RQ13] fine gain register 0x6F, reset 0x80
// [RQ14] fine gain tenth dB, code 8 unity
// [RQ15] fine gain low nibble reads zero
// [RQ16] separate bandwidth select, audio or wide
// [RQ17] fields read back, gains apply directly
//
// The APB register port was decided locally.

`include "out2_gain_regs.svh"

module output_two_dac_gain_regs
    import out2_gain_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output analog_cfg_t analog_cfg,
    output gain_t chan_a_gain
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // true when the address is word aligned and its word address matches a register index
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
    endfunction

    logic sel_cfg;
    logic sel_vol;
    logic sel_fine;
    logic sel_bw;
    logic sel_stat;
    logic mapped;
    logic setup;
    logic access;
    logic wr_en;

    // one select per register
    assign sel_cfg = hit(paddr, `CFG_IDX);
    assign sel_vol = hit(paddr, `VOL_IDX);
    assign sel_fine = hit(paddr, `FINE_IDX);
    assign sel_bw = hit(paddr, `BW_IDX);
    assign sel_stat = hit(paddr, `STAT_IDX);
    assign mapped = sel_cfg | sel_vol | sel_fine | sel_bw | sel_stat;

    // bus phases; slave answers with no wait states
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped; // unmapped address errors
    assign wr_en = access & pwrite & mapped & pstrb[0];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------

    logic [7:0] cfg_ff;
    logic [7:0] vol_ff;
    logic [3:0] fine_ff;
    logic bw_ff;
    logic [31:0] prdata_ff;
    logic [7:0] status;
    logic [7:0] nxt_rdata;

    // output configuration register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_ff <= `CFG_RST; // see [RQ1]
        else if (wr_en && sel_cfg)
            cfg_ff <= pwdata[7:0]; // see [RQ2] see [RQ3] see [RQ6] see [RQ7] see [RQ9]
    end

    // channel a digital volume register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vol_ff <= `VOL_RST; // see [RQ10]
        else if (wr_en && sel_vol)
            vol_ff <= pwdata[7:0];
    end

    // channel a fine gain register, only the upper nibble is stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fine_ff <= 4'(`FINE_RST >> `FG_LO); // see [RQ13]
        else if (wr_en && sel_fine)
            fine_ff <= pwdata[`FG_HI:`FG_LO]; // see [RQ14]
    end

    // channel bandwidth select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bw_ff <= 1'(`BW_RST);
        else if (wr_en && sel_bw)
            bw_ff <= pwdata[0]; // see [RQ16]
    end

    // ------------------------------------------------------------
    // status and read path
    // ------------------------------------------------------------

    // flags settings that the host should not have made
    always_comb
    begin
        status = 8'h00;
        status[0] = cfg_ff[`LVL_HI:`LVL_LO] == `LVL_RSVD;
        status[1] = cfg_ff[`FS_BIT] & bw_ff; // see [RQ8]
        status[2] = (cfg_ff[`LVL_HI:`LVL_LO] == `LVL_M12) & cfg_ff[`BYP_BIT]; // see [RQ5]
    end

    // read mux; reserved bits read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (sel_cfg)
            nxt_rdata = cfg_ff; // see [RQ17]
        else if (sel_vol)
            nxt_rdata = vol_ff;
        else if (sel_fine)
            nxt_rdata = {fine_ff, 4'h0}; // see [RQ15]
        else if (sel_bw)
            nxt_rdata = {7'h00, bw_ff};
        else if (sel_stat)
            nxt_rdata = status;
    end

    // read data captured in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (setup)
            prdata_ff <= {24'h00_0000, nxt_rdata};
    end

    assign prdata = prdata_ff;

    // ------------------------------------------------------------
    // decoded outputs
    // ------------------------------------------------------------

    analog_cfg_t cfg_out_ff;
    gain_t gain_ff;

    // analogue controls follow the stored fields one cycle later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_out_ff <= '{drv_line_out, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0};
        end
        else
        begin
            cfg_out_ff.neg_leg_drive_sel <= drive_t'(cfg_ff[`DRV_HI:`DRV_LO]); // see [RQ2]
            cfg_out_ff.neg_leg_level_sel <= cfg_ff[`LVL_HI:`LVL_LO]; // see [RQ3]
            cfg_out_ff.pos_bypass_impedance_sel <= cfg_ff[`BYP_BIT]; // see [RQ6]
            cfg_out_ff.full_scale_sel <= cfg_ff[`FS_BIT]; // see [RQ7]
            cfg_out_ff.common_mode_tolerance_sel <= cfg_ff[`CM_BIT]; // see [RQ9]
            cfg_out_ff.channel_bandwidth_sel <= bw_ff; // see [RQ16]
        end
    end

    // signed gains relative to unity, applied with no host action
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_ff <= '{1'b0, 9'sh000, 5'sh00};
        end
        else
        begin
            gain_ff.mute <= vol_ff == 8'h00; // see [RQ11]
            gain_ff.volume_half_db <= $signed({1'b0, vol_ff} - `VOL_UNITY); // see [RQ12]
            gain_ff.fine_tenth_db <= $signed({1'b0, fine_ff} - `FG_UNITY); // see [RQ14]
        end
    end

    assign analog_cfg = cfg_out_ff;
    assign chan_a_gain = gain_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // every config read returns the stored value
    cfg_readback_a: assert property ( // see [RQ1]
        (setup && sel_cfg) |=> prdata[7:0] == $past(cfg_ff))
        else $error("config readback wrong");

    // drive field reaches output two cycles after write
    drive_follow_a: assert property ( // see [RQ2]
        (wr_en && sel_cfg) |-> ##2 analog_cfg.neg_leg_drive_sel == $past(pwdata[7:6], 2))
        else $error("drive select not applied");

    // level field reaches output two cycles after write
    level_follow_a: assert property ( // see [RQ3]
        (wr_en && sel_cfg) |-> ##2 analog_cfg.neg_leg_level_sel == $past(pwdata[5:3], 2))
        else $error("level select not applied");

    // impedance, full scale and tolerance bits follow the write
    low_bits_follow_a: assert property ( // see [RQ7]
        (wr_en && sel_cfg) |-> ##2 {analog_cfg.pos_bypass_impedance_sel,
            analog_cfg.full_scale_sel,
            analog_cfg.common_mode_tolerance_sel} == $past(pwdata[2:0], 2))
        else $error("low config bits not applied");

    // zero volume mutes, nonzero does not
    mute_code_a: assert property ( // see [RQ11]
        chan_a_gain.mute == ($past(vol_ff) == 8'h00))
        else $error("mute does not match volume");

    // unity volume code gives zero gain
    volume_unity_a: assert property ( // see [RQ12]
        (wr_en && sel_vol && pwdata[7:0] == 8'hC9) |-> ##2 chan_a_gain.volume_half_db == 9'sh000)
        else $error("volume unity wrong");

    // top volume code gives plus 54 half steps
    volume_top_a: assert property ( // see [RQ12]
        (wr_en && sel_vol && pwdata[7:0] == 8'hFF) |-> ##2 chan_a_gain.volume_half_db == 9'sd54)
        else $error("volume top wrong");

    // fine gain code 0 gives minus eight tenths
    fine_bottom_a: assert property ( // see [RQ14]
        (wr_en && sel_fine && pwdata[7:4] == 4'h0) |-> ##2 chan_a_gain.fine_tenth_db == -5'sd8)
        else $error("fine gain bottom wrong");

    // fine gain low nibble always reads zero
    fine_nibble_a: assert property ( // see [RQ15]
        (setup && sel_fine) |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h00_0000)
        else $error("fine gain reserved bits nonzero");

    // bandwidth select follows its write
    bw_follow_a: assert property ( // see [RQ16]
        (wr_en && sel_bw) |-> ##2 analog_cfg.channel_bandwidth_sel == $past(pwdata[0], 2))
        else $error("bandwidth select not applied");

    // status shows high full scale with wide band, and only then
    fs_status_a: assert property ( // see [RQ8]
        (setup && sel_stat) |=> prdata[1] == $past(cfg_ff[`FS_BIT] & bw_ff))
        else $error("full scale conflict not flagged");

    // unmapped access errors, mapped does not
    unmapped_err_a: assert property (
        access |-> pslverr == !mapped)
        else $error("slave error wrong");

    // volume register holds unless written
    volume_hold_a: assert property ( // see [RQ17]
        !(wr_en && sel_vol) |=> $stable(vol_ff))
        else $error("volume changed without write");

    // a written volume code is stored as written
    vol_write_a: assert property ( // see [RQ10]
        (wr_en && sel_vol) |=> vol_ff == $past(pwdata[7:0]))
        else $error("volume write not stored");

    // fine gain follows its write as code minus eight
    fine_follow_a: assert property ( // see [RQ14]
        (wr_en && sel_fine) |-> ##2
            chan_a_gain.fine_tenth_db == $signed({1'b0, $past(pwdata[7:4], 2)} - 5'h08))
        else $error("fine gain not applied");

    // config register holds unless written
    cfg_hold_a: assert property ( // see [RQ17]
        !(wr_en && sel_cfg) |=> $stable(cfg_ff))
        else $error("config changed without write");

    // fine gain register holds unless written
    fine_hold_a: assert property ( // see [RQ17]
        !(wr_en && sel_fine) |=> $stable(fine_ff))
        else $error("fine gain changed without write");

    // bandwidth select holds unless written
    bw_hold_a: assert property ( // see [RQ16]
        !(wr_en && sel_bw) |=> $stable(bw_ff))
        else $error("bandwidth changed without write");

endmodule

// ===== sim/apb_host_model.sv
// apb host model that performs single register transfers
module apb_host_model
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    // one transfer: setup, access until pready, then release
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        logic [31:0] wd;
        wd = d;
        if (a == 12'h1BC)
            wd[3:0] = 4'h0; // reserved nibble only ever written as zero
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show no stale value
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule

// ===== sim/output_two_dac_gain_regs_test.sv
// self-checking bench for the output two gain register bank
`include "out2_gain_regs.svh"

module output_two_dac_gain_regs_test;
    import out2_gain_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [11:0] CFG = {2'b00, `CFG_IDX, 2'b00};
    localparam logic [11:0] VOL = {2'b00, `VOL_IDX, 2'b00};
    localparam logic [11:0] FINE = {2'b00, `FINE_IDX, 2'b00};
    localparam logic [11:0] BW = {2'b00, `BW_IDX, 2'b00};
    localparam logic [11:0] STAT = {2'b00, `STAT_IDX, 2'b00};

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic e;
    analog_cfg_t analog_cfg;
    gain_t chan_a_gain;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    always #25 pclk = ~pclk;

    apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    output_two_dac_gain_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_cfg(analog_cfg),
        .chan_a_gain(chan_a_gain));

    //--------------------------------------------------
    // shared tasks
    //--------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, 4'hF, r, e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        host.xfer(1'b0, a, 32'h0, 4'hF, r, e);
        check(r, {24'h0, exp});
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    //--------------------------------------------------
    // scenarios
    //--------------------------------------------------
    task automatic t_reset;
        rd_chk(CFG, 8'h20);
        rd_chk(VOL, 8'hC9);
        rd_chk(FINE, 8'h80);
        check(32'(analog_cfg), 32'h040);
        check(32'(chan_a_gain), 32'h0);
    endtask

    task automatic t_drive;
        for (int d = 0; d < 4; d++)
        begin
            wr(CFG, {2'(d), 3'h4, 3'h0});
            check(32'(analog_cfg.neg_leg_drive_sel), 32'(d));
            rd_chk(CFG, {2'(d), 3'h4, 3'h0});
        end
    endtask

    // level 6 only with 4.4k, high scale only in audio band
    task automatic t_level;
        logic byp;
        for (int l = 0; l < 7; l++)
        begin
            byp = (l != 6);
            wr(CFG, {2'h3, 3'(l), byp, l[0], ~l[0]});
            check(32'(analog_cfg),
                {23'h0, 2'h3, 3'(l), byp, l[0], ~l[0], 1'b0});
        end
    endtask

    task automatic t_volume;
        int codes[6] = '{0, 1, 2, 201, 202, 255};
        foreach (codes[i])
        begin
            wr(VOL, 8'(codes[i]));
            rd_chk(VOL, 8'(codes[i]));
            if (codes[i] == 0)
                check(32'(chan_a_gain.mute), 32'h1);
            else
                check({chan_a_gain.mute, chan_a_gain.volume_half_db},
                    {1'b0, 9'(codes[i] - 201)});
        end
    endtask

    task automatic t_fine;
        int codes[3] = '{0, 8, 15};
        foreach (codes[i])
        begin
            wr(FINE, {4'(codes[i]), 4'hF});
            rd_chk(FINE, {4'(codes[i]), 4'h0});
            check(32'(chan_a_gain.fine_tenth_db), 32'(5'(codes[i] - 8)));
        end
    endtask

    task automatic t_bw_unmapped;
        wr(CFG, 8'h30);
        wr(BW, 8'h01);
        check(32'(analog_cfg.channel_bandwidth_sel), 32'h1);
        host.xfer(1'b1, 12'h1C0, 32'hFF, 4'hF, r, e);
        check(32'(e), 32'h1);
        host.xfer(1'b1, 12'h1B5, 32'hFF, 4'hF, r, e);
        check(32'(e), 32'h1);
        rd_chk(CFG, 8'h30);
        wr(BW, 8'h00);
        check(32'(analog_cfg.channel_bandwidth_sel), 32'h0);
    endtask

    // writes without the low strobe or to status are ignored
    task automatic t_refused;
        wr(VOL, 8'h40);
        host.xfer(1'b1, VOL, 32'h11, 4'hE, r, e);
        check(32'(e), 32'h0);
        rd_chk(VOL, 8'h40);
        check(32'(chan_a_gain.volume_half_db), 32'(9'(64 - 201)));
        host.xfer(1'b1, STAT, 32'hFF, 4'hF, r, e);
        rd_chk(STAT, 8'h00);
    endtask

    //--------------------------------------------------
    // sequence and timeout
    //--------------------------------------------------
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_drive;
        t_level;
        t_volume;
        t_fine;
        t_bw_unmapped;
        t_refused;
        wrap_up;
    end
endmodule
